/* hw/pmt_sync_edge.v */
// Three-stage synchroniser with a rising-edge detector for an external pin.
// Assumes the pin toggles well below half the system clock rate.
`default_nettype none

module pmt_sync_edge (
    input  wire sys_clk_i,
    input  wire sys_rst_i,
    input  wire async_i,
    output reg  rise_o
);

    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;
    reg stable_reg;
    wire agree;

    // A change only counts once the second and third stages agree.
    assign agree = (stage2_reg == stage3_reg);

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            stable_reg <= 1'b0;
            rise_o     <= 1'b0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (agree) begin
                stable_reg <= stage3_reg;
            end
            rise_o <= agree & stage3_reg & ~stable_reg;
        end
    end

endmodule

`default_nettype wire

/* hw/pmt_timer.v */
// Power-management free-running timer with byte-wide read-only count registers.
// Assumes a simple system I/O read/write strobe port, an I/O base supplied by
// a configuration register, and control bits held by neighbouring logic.
`include "pmt_timer_defs.vh"
`default_nettype none

module pmt_timer (
    input  wire                     sys_clk_i,
    input  wire                     sys_rst_i,
    input  wire                     reference_clock_input_i,
    input  wire                     working_state_i,
    input  wire [`PMT_ADDR_W-1:0]   io_base_i,
    input  wire [`PMT_ADDR_W-1:0]   io_addr_i,
    input  wire                     io_rd_i,
    input  wire                     io_wr_i,
    input  wire [`PMT_DATA_W-1:0]   io_wdata_i,
    input  wire                     timer_carry_irq_enable_i,
    input  wire                     timer_carry_status_clr_i,
    input  wire                     sci_route_select_i,
    input  wire                     smi_route_enable_i,
    output reg  [`PMT_DATA_W-1:0]   io_rdata_o,
    output reg                      io_rvalid_o,
    output reg                      io_hit_o,
    output reg  [`PMT_COUNT_W-1:0]  pm_timer_count_o,
    output reg                      timer_carry_status_o,
    output reg                      sci_irq_o,
    output reg                      smi_irq_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire                     ref_rise;
    wire                     count_step;
    wire                     carry_toggle;
    wire                     carry_set;
    wire [`PMT_ADDR_W-1:0]   rel_addr;
    wire [`PMT_BYTE_COUNT-1:0] byte_hit;
    wire                     reserved_hit;
    wire                     any_hit;
    wire                     rd_hit;
    wire                     acc_hit;
    wire                     irq_cause;
    wire [`PMT_DATA_W-1:0]   lane_data [0:`PMT_BYTE_COUNT-1];

    reg  [`PMT_COUNT_W-1:0]  count_reg;
    reg  [`PMT_COUNT_W-1:0]  count_next;
    reg                      carry_status_reg;
    reg                      carry_status_next;
    reg  [`PMT_DATA_W-1:0]   rdata_next;

    // ****************************************************************
    // Reference clock edge detection
    // ****************************************************************
    // A stopped reference clock yields no edges, so the count simply holds.
    // The pin passes three flip-flops, so each count lands a few system clocks
    // after the pin rises; the reference must stay well below half the system rate.
    // A rise that is shorter than two system clocks may be missed altogether.
    pmt_sync_edge u_ref_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (reference_clock_input_i),
        .rise_o    (ref_rise)
    );

    // ****************************************************************
    // Counter
    // ****************************************************************
    // The step is a plain add, so the count wraps from all ones to zero.
    assign count_step = ref_rise & working_state_i;

    always @* begin
        count_next = count_reg;
        if (count_step) begin
            count_next = count_reg + `PMT_COUNT_STEP;
        end
    end

    // Only the master reset clears the count; a clock stall never does.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            count_reg <= `PMT_COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // ****************************************************************
    // Carry status flag
    // ****************************************************************
    // Comparing the current and the next top bit catches rising and falling changes.
    assign carry_toggle = count_reg[`PMT_COUNT_MSB] ^ count_next[`PMT_COUNT_MSB];
    // A toggle that finds the flag still set is not a new setting.
    assign carry_set    = carry_toggle & ~carry_status_reg;

    // A toggle in the same cycle as a clear keeps the flag set.
    always @* begin
        carry_status_next = carry_status_reg;
        if (timer_carry_status_clr_i) begin
            carry_status_next = 1'b0;
        end
        if (carry_toggle) begin
            carry_status_next = 1'b1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            carry_status_reg <= 1'b0;
        end else begin
            carry_status_reg <= carry_status_next;
        end
    end

    // ****************************************************************
    // Interrupt routing
    // ****************************************************************
    // A clear landing in the same cycle as a toggle still counts as a new setting.
    assign irq_cause = carry_set | (carry_toggle & timer_carry_status_clr_i);

    // One pulse per setting of the flag while enabled, on SCI by the route select, else on SMI if its route is enabled.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sci_irq_o <= 1'b0;
            smi_irq_o <= 1'b0;
        end else begin
            sci_irq_o <= irq_cause & timer_carry_irq_enable_i & sci_route_select_i;
            smi_irq_o <= irq_cause & timer_carry_irq_enable_i & ~sci_route_select_i
                         & smi_route_enable_i;
        end
    end

    // ****************************************************************
    // I/O address decode
    // ****************************************************************
    // The offset wraps at 64K, so a base near the top of I/O space still decodes.
    assign rel_addr = io_addr_i - io_base_i;

    // Each timer byte gets its own offset and its own lane of the count.
    genvar b;
    generate
        for (b = 0; b < `PMT_BYTE_COUNT; b = b + 1) begin : g_byte_hit
            localparam integer           lane_idx = b;
            localparam [`PMT_ADDR_W-1:0] lane_ofs = `PMT_OFS_TMR_LOW + lane_idx[`PMT_ADDR_W-1:0];
            assign byte_hit[b]  = (rel_addr == lane_ofs);
            assign lane_data[b] = count_reg[b*`PMT_DATA_W +: `PMT_DATA_W];
        end
    endgenerate

    assign reserved_hit = (rel_addr == `PMT_OFS_CTL_FOUR) | (rel_addr == `PMT_OFS_TMR_FOUR);
    assign any_hit      = (|byte_hit) | reserved_hit;

    // ****************************************************************
    // Access qualifiers
    // ****************************************************************
    // A read answers only when it hits a mapped offset; a write only raises the hit flag.
    assign rd_hit  = io_rd_i & any_hit;
    assign acc_hit = (io_rd_i | io_wr_i) & any_hit;

    // ****************************************************************
    // Read data
    // ****************************************************************
    // The bytes show the live count with no snapshot, so software reading all three
    // must read again when a carry out of a lower byte falls between its accesses.
    // Writes are decoded only so the hit flag reports them; no state changes.
    always @* begin
        rdata_next = `PMT_DATA_ZERO;
        if (byte_hit[0]) begin
            rdata_next = lane_data[0];
        end else if (byte_hit[1]) begin
            rdata_next = lane_data[1];
        end else if (byte_hit[2]) begin
            rdata_next = lane_data[2];
        end else if (reserved_hit) begin
            rdata_next = `PMT_RESERVED_VALUE;
        end
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            io_rdata_o  <= `PMT_DATA_ZERO;
            io_rvalid_o <= 1'b0;
            io_hit_o    <= 1'b0;
        end else begin
            io_rvalid_o <= rd_hit;
            io_hit_o    <= acc_hit;
            // Idle cycles drive zero so the data lines never carry a stale byte.
            if (rd_hit) begin
                io_rdata_o <= rdata_next;
            end else begin
                io_rdata_o <= `PMT_DATA_ZERO;
            end
        end
    end

    // ****************************************************************
    // Status outputs
    // ****************************************************************
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pm_timer_count_o     <= `PMT_COUNT_RESET;
            timer_carry_status_o <= 1'b0;
        end else begin
            // Taking the next value keeps the output equal to the internal count.
            pm_timer_count_o     <= count_next;
            timer_carry_status_o <= carry_status_next;
        end
    end

endmodule

`default_nettype wire

/* hw/pmt_timer_defs.vh */
// Constants for the power-management free-running timer block.
// Assumes a 16-bit system I/O address and an 8-bit I/O data path.
`ifndef PMT_TIMER_DEFS_VH
`define PMT_TIMER_DEFS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define PMT_ADDR_W          16
`define PMT_DATA_W          8
`define PMT_COUNT_W         24
`define PMT_COUNT_MSB       23
`define PMT_BYTE_COUNT      3

// ****************************************************************
// Register offsets from the configured I/O base
// ****************************************************************
`define PMT_OFS_CTL_FOUR    16'h0007
`define PMT_OFS_TMR_LOW     16'h0008
`define PMT_OFS_TMR_MID     16'h0009
`define PMT_OFS_TMR_HIGH    16'h000A
`define PMT_OFS_TMR_FOUR    16'h000B

// ****************************************************************
// Reset and fixed values
// ****************************************************************
`define PMT_COUNT_RESET     24'h000000
`define PMT_COUNT_STEP      24'h000001
`define PMT_DATA_ZERO       8'h00
`define PMT_RESERVED_VALUE  8'h00

// ****************************************************************
// Reference and system clock rates
// ****************************************************************
`define PMT_REF_CLK_HZ      3579545
`define PMT_SYS_CLK_HZ      50000000

`endif

/* verification/pmt_timer_chk.sv */
// Concurrent checks on the ports of the power-management timer.
// Assumes it is bound to every pmt_timer instance and sees only its ports.
`include "pmt_timer_defs.vh"
`default_nettype none
module pmt_timer_chk (
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        working_state_i,
    input wire logic [15:0] io_base_i,
    input wire logic [15:0] io_addr_i,
    input wire logic        io_rd_i,
    input wire logic        io_wr_i,
    input wire logic        timer_carry_irq_enable_i,
    input wire logic        sci_route_select_i,
    input wire logic        smi_route_enable_i,
    input wire logic [7:0]  io_rdata_o,
    input wire logic        io_rvalid_o,
    input wire logic        io_hit_o,
    input wire logic [23:0] pm_timer_count_o,
    input wire logic        timer_carry_status_o,
    input wire logic        sci_irq_o,
    input wire logic        smi_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [15:0] ofs = io_addr_i - io_base_i;
    wire        rsv = ofs == `PMT_OFS_CTL_FOUR || ofs == `PMT_OFS_TMR_FOUR;
    wire        map = ofs >= `PMT_OFS_CTL_FOUR && ofs <= `PMT_OFS_TMR_FOUR;
    wire [23:0] c   = pm_timer_count_o;
    function automatic logic [7:0] pick(input logic [23:0] v, input logic [15:0] o);
        return 8'(v >> {o[1:0], 3'b000});
    endfunction
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    rsv_zero_a: assert property (io_rd_i && rsv |=> io_rvalid_o && io_rdata_o == 8'h00)
        else $error("reserved byte read not zero");
    byte_map_a: assert property (io_rd_i && map && !rsv |=> io_rvalid_o && io_hit_o &&
        (io_rdata_o == pick(c, $past(ofs)) || io_rdata_o == pick($past(c), $past(ofs))))
        else $error("timer byte read wrong");
    count_step_a: assert property (c != $past(c) |-> c == $past(c) + 24'h000001)
        else $error("count moved by other than one");
    idle_hold_a: assert property (!working_state_i [*2] |=> $stable(c))
        else $error("count moved outside working state");
    reset_clear_a: assert property ($fell(sys_rst_i) |-> c == 24'h000000 && !timer_carry_status_o)
        else $error("count not cleared by reset");
    write_ignored_a: assert property (io_wr_i && map |=> io_hit_o && !io_rvalid_o &&
        (c == $past(c) || c == $past(c) + 24'h000001))
        else $error("write disturbed count");
    unmapped_quiet_a: assert property ((io_rd_i || io_wr_i) && !map |=> !io_hit_o && io_rdata_o == 8'h00)
        else $error("unmapped access answered");
    carry_cause_a: assert property ($rose(timer_carry_status_o) |-> c[23] != $past(c[23]))
        else $error("carry flag without top bit change");
    sci_route_a: assert property (sci_irq_o |-> timer_carry_status_o &&
        $past(timer_carry_irq_enable_i && sci_route_select_i) && c[23] != $past(c[23]))
        else $error("sci pulse without cause");
    irq_masked_a: assert property (!timer_carry_irq_enable_i |=> !sci_irq_o && !smi_irq_o)
        else $error("interrupt while disabled");
    smi_route_a: assert property (smi_irq_o |-> $past(!sci_route_select_i && smi_route_enable_i))
        else $error("smi pulse on wrong route");
    cover property (io_rd_i && map && !rsv);
    cover property (io_wr_i && map);
    cover property (c != $past(c));
endmodule
bind pmt_timer pmt_timer_chk pmt_timer_chk_inst (.sys_clk_i, .sys_rst_i, .working_state_i, .io_base_i,
    .io_addr_i, .io_rd_i, .io_wr_i, .timer_carry_irq_enable_i, .sci_route_select_i, .smi_route_enable_i,
    .io_rdata_o, .io_rvalid_o, .io_hit_o, .pm_timer_count_o, .timer_carry_status_o, .sci_irq_o, .smi_irq_o);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the power-management timer.
// Assumes pmt_timer and its checker are compiled before it.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, pin = 0, work = 1, rd = 0, wr = 0, en = 0, clr = 0, sci = 0, smi = 0;
    logic [15:0] base = 16'h0000, addr = 16'h0000, o;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [23:0] cnt, ex;
    logic        rvalid, hit, sts, sci_o, smi_o;
    integer      seed = 32'h1DBC5597, miscompares = 0, comparisons = 0;
    pmt_timer pmt_timer_inst (.sys_clk_i(clk), .sys_rst_i(rst), .reference_clock_input_i(pin),
        .working_state_i(work), .io_base_i(base), .io_addr_i(addr), .io_rd_i(rd), .io_wr_i(wr),
        .io_wdata_i(wdata), .timer_carry_irq_enable_i(en), .timer_carry_status_clr_i(clr),
        .sci_route_select_i(sci), .smi_route_enable_i(smi), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
        .io_hit_o(hit), .pm_timer_count_o(cnt), .timer_carry_status_o(sts), .sci_irq_o(sci_o),
        .smi_irq_o(smi_o));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] exp_b(input logic [23:0] c, input logic [15:0] k);
        return (k == 16'h0007 || k == 16'h000B) ? 8'h00 : c >> {k[1:0], 3'b000};
    endfunction
    task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic io(input logic w, input logic [15:0] k, input logic [7:0] e, input logic h);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= base + k;
        wdata <= 8'($random(seed));
        @(posedge clk);
        rd <= 0;
        wr <= 0;
        #1;
        check("rdata", e, rdata);
        check("hit", h, hit);
        check("rvalid", h && !w, rvalid);
    endtask
    task automatic rdall();
        for (int k = 7; k <= 11; k++) io(0, k[15:0], exp_b(ex, k[15:0]), 1);
        check("count", ex, cnt);
        check("carry", 0, sts);
        check("sci", 0, sci_o);
        check("smi", 0, smi_o);
    endtask
    task automatic run(input int n);
        repeat (n) begin
            @(posedge clk);
            pin <= 1;
            {en, sci, smi, clr} <= 4'($random(seed));
            repeat (4 + ($random(seed) & 3)) @(posedge clk);
            pin <= 0;
            repeat (4 + ($random(seed) & 3)) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic close_out();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end
    initial begin
        base <= $random(seed);
        ex = 24'h000000;
        repeat (3) @(posedge clk);
        rst <= 0;
        rdall();
        run(20);
        ex = 24'h000014;
        rdall();
        @(posedge clk) work <= 0;
        run(5);
        rdall();
        @(posedge clk) work <= 1;
        repeat (40) @(posedge clk);
        run(7);
        ex = 24'h00001B;
        rdall();
        for (int k = 7; k <= 11; k++) io(1, k[15:0], 8'h00, 1);
        rdall();
        io(0, 16'h0006, 8'h00, 0);
        io(0, 16'h000C, 8'h00, 0);
        repeat (10) begin
            o = $random(seed);
            if (o >= 16'h0007 && o <= 16'h000B) o = 16'h0000;
            io($random(seed), o, 8'h00, 0);
        end
        @(posedge clk) rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        ex = 24'h000000;
        rdall();
        run(3);
        ex = 24'h000003;
        rdall();
        close_out();
    end
endmodule
`default_nettype wire
